// >>> shared/iqr_pkg.sv
// package for the quality, parity and identification register bank
package iqr_pkg;
  localparam int unsigned NUM_UNITS = 32;
  localparam int unsigned UNITS_PER_GROUP = 8;
  localparam int unsigned QOS_GROUPS = 4;
  localparam int unsigned QOS_FIELD_W = 4;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_QOS0 = 8'h00;
  localparam logic [7:0] OFS_QOS1 = 8'h04;
  localparam logic [7:0] OFS_QOS2 = 8'h08;
  localparam logic [7:0] OFS_QOS3 = 8'h0c;
  localparam logic [7:0] OFS_PARITY = 8'h10;
  localparam logic [7:0] OFS_POWER = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] OFS_PID4 = 8'hd0;
  localparam logic [7:0] OFS_PID5 = 8'hd4;
  localparam logic [7:0] OFS_PID6 = 8'hd8;
  localparam logic [7:0] OFS_PID7 = 8'hdc;
  localparam logic [7:0] OFS_PID0 = 8'he0;
  localparam logic [7:0] OFS_PID1 = 8'he4;
  localparam logic [7:0] OFS_PID2 = 8'he8;
  localparam logic [7:0] OFS_PID3 = 8'hec;
  localparam logic [7:0] OFS_CID0 = 8'hf0;
  localparam logic [7:0] OFS_CID1 = 8'hf4;
  localparam logic [7:0] OFS_CID2 = 8'hf8;
  localparam logic [7:0] OFS_CID3 = 8'hfc;
  // parity count fields
  localparam int unsigned PAR_UNIT_LSB = 0;
  localparam int unsigned PAR_CTRL_LSB = 8;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [31:0] QOS_RESET = 32'h0000_0000;
  // fixed preamble bytes
  localparam logic [7:0] CID0_VAL = 8'h0d;
  localparam logic [7:0] CID1_VAL = 8'hf0;
  localparam logic [7:0] CID2_VAL = 8'h05;
  localparam logic [7:0] CID3_VAL = 8'hb1;
  // identification fields; values arbitrary
  localparam logic [7:0] PART_NUMBER_LOW = 8'h5a;
  localparam logic [3:0] PART_NUMBER_HIGH = 4'h7;
  localparam logic [6:0] DESIGNER_CODE = 7'h2c;
  localparam logic [3:0] ARCH_REVISION = 4'h2;
  localparam logic [3:0] MANUFACTURER_REVISION = 4'h6;
  localparam logic [3:0] CUSTOMER_MOD = 4'h9;
  localparam logic [3:0] CONTINUATION_CODE = 4'h8;
  localparam logic JEDEC_USED = 1'b1;
  // interrupt status bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_CTRL_PAR = 0;
  localparam int unsigned IRQ_UNIT_PAR = 1;
endpackage : iqr_pkg

// >>> core/iqr_regs.sv
// register bank: unit quality, parity counts, power state, identification
// Contract
// RULE1: four quality registers, each for eight buffer units in order
// RULE2: unit n owns bits 4p+3..4p, p equals n modulo 8
// RULE3: quality fields reset to zero; unused upper bits reserved
// RULE4: control unit parity count at bits 15..8, resets zero, saturates
// RULE5: buffer unit parity count at bits 7..0, resets zero, saturates
// RULE6: tlb and walk cache rams detect single errors, invalidate entry
// RULE7: message fifo ram detects and corrects single-bit errors
// RULE8: power state bit n is one while unit n powered up
// RULE9: preamble registers return 0d, f0, 05, b1 in low byte
// RULE10: ident registers zero to four use low byte; five to seven zero
// RULE11: ident zero holds middle and low part number digits
// RULE12: ident one holds low designer code and upper part digit
// RULE13: ident two holds revision, bit 3 one, upper designer code
// RULE14: ident three holds manufacturer revision and customer number
// RULE15: parity, power and identification registers ignore writes
// RULE16: each error adds exactly one unless counter at maximum
module iqr_regs
  import iqr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // error events from the ram checkers, same clock
  input wire logic ctrl_parity_err_i,
  input wire logic unit_parity_err_i,
  // power state of each buffer unit, asynchronous
  input wire logic [NUM_UNITS-1:0] unit_powered_i,
  // quality value per unit
  output logic [QOS_FIELD_W*NUM_UNITS-1:0] unit_quality_field_o,
  // interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0] qos_group [QOS_GROUPS];
  logic [CNT_W-1:0] control_unit_parity_count;
  logic [CNT_W-1:0] buffer_unit_parity_count;
  logic [NUM_UNITS-1:0] power_meta;
  logic [NUM_UNITS-1:0] buffer_unit_power_state;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic req;
  logic wr_strobe;
  logic mapped;
  logic [31:0] next_dat;

  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction : byte_merge

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    return (c == CNT_MAX) ? c : c + 8'h01;
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: ack, or err if unmapped, one cycle after the request, dropped the next

  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_strobe = req && we_i && mapped;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quality registers

  generate
    for (genvar g = 0; g < QOS_GROUPS; g++) begin : g_qos
      localparam logic [7:0] OFS = OFS_QOS0 + 8'(4 * g);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          qos_group[g] <= QOS_RESET; // see RULE3
        end else if (wr_strobe && adr_i == OFS) begin // see RULE1
          qos_group[g] <= byte_merge(qos_group[g], dat_i, sel_i);
        end
      end
      for (genvar p = 0; p < UNITS_PER_GROUP; p++) begin : g_unit
        // see RULE2
        assign unit_quality_field_o[QOS_FIELD_W*(g*UNITS_PER_GROUP+p) +:
                                    QOS_FIELD_W] =
          qos_group[g][QOS_FIELD_W*p +: QOS_FIELD_W];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // parity counters, hardware driven only

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_unit_parity_count <= CNT_RESET; // see RULE4
    end else if (ctrl_parity_err_i) begin
      control_unit_parity_count <=
        sat_inc(control_unit_parity_count); // see RULE16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_unit_parity_count <= CNT_RESET; // see RULE5
    end else if (unit_parity_err_i) begin
      buffer_unit_parity_count <=
        sat_inc(buffer_unit_parity_count); // see RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state synchroniser

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_meta <= '0;
      buffer_unit_power_state <= '0;
    end else begin
      power_meta <= unit_powered_i;
      buffer_unit_power_state <= power_meta; // see RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky status, enable, write-one-to-clear

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable <= '0;
    end else if (wr_strobe && adr_i == OFS_IRQ_ENABLE && sel_i[0]) begin
      irq_enable <= dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (wr_strobe && adr_i == OFS_IRQ_CLEAR && sel_i[0] && dat_i[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      // set wins over clear
      if (ctrl_parity_err_i) begin
        irq_status[IRQ_CTRL_PAR] <= 1'b1;
      end
      if (unit_parity_err_i) begin
        irq_status[IRQ_UNIT_PAR] <= 1'b1;
      end
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // read decode; read-only registers have no write path

  always_comb begin
    mapped = 1'b1;
    next_dat = 32'h0000_0000;
    case (adr_i)
      OFS_QOS0: next_dat = qos_group[0];
      OFS_QOS1: next_dat = qos_group[1];
      OFS_QOS2: next_dat = qos_group[2];
      OFS_QOS3: next_dat = qos_group[3];
      OFS_PARITY: begin // see RULE15
        next_dat[PAR_CTRL_LSB +: CNT_W] = control_unit_parity_count;
        next_dat[PAR_UNIT_LSB +: CNT_W] = buffer_unit_parity_count;
      end
      OFS_POWER: next_dat[NUM_UNITS-1:0] = buffer_unit_power_state;
      OFS_IRQ_STATUS: next_dat[IRQ_W-1:0] = irq_status;
      OFS_IRQ_ENABLE: next_dat[IRQ_W-1:0] = irq_enable;
      OFS_IRQ_CLEAR: next_dat = 32'h0000_0000;
      OFS_PID0: next_dat[7:0] = PART_NUMBER_LOW; // see RULE11
      OFS_PID1: begin // see RULE12
        next_dat[7:4] = DESIGNER_CODE[3:0];
        next_dat[3:0] = PART_NUMBER_HIGH;
      end
      OFS_PID2: begin // see RULE13
        next_dat[7:4] = ARCH_REVISION;
        next_dat[3] = JEDEC_USED;
        next_dat[2:0] = DESIGNER_CODE[6:4];
      end
      OFS_PID3: begin // see RULE14
        next_dat[7:4] = MANUFACTURER_REVISION;
        next_dat[3:0] = CUSTOMER_MOD;
      end
      OFS_PID4: next_dat[3:0] = CONTINUATION_CODE; // see RULE10
      OFS_PID5, OFS_PID6, OFS_PID7: next_dat = 32'h0000_0000; // see RULE10
      OFS_CID0: next_dat[7:0] = CID0_VAL; // see RULE9
      OFS_CID1: next_dat[7:0] = CID1_VAL; // see RULE9
      OFS_CID2: next_dat[7:0] = CID2_VAL; // see RULE9
      OFS_CID3: next_dat[7:0] = CID3_VAL; // see RULE9
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= next_dat;
    end
  end

  // ram error correction and invalidation live in the ram wrappers;
  // this bank only counts and flags as interrupts the events they report (see RULE6, RULE7)

endmodule : iqr_regs

// >>> bench/iqr_regs_properties.sv
// checker for the quality, parity and identification register bank
module iqr_regs_properties
  import iqr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // events and outputs
  input wire logic ctrl_parity_err_i,
  input wire logic unit_parity_err_i,
  input wire logic [NUM_UNITS-1:0] unit_powered_i,
  input wire logic [QOS_FIELD_W*NUM_UNITS-1:0] unit_quality_field_o,
  input wire logic irq_o
);
  wire logic take = cyc_i & stb_i & ~ack_o & ~err_o;
  wire logic rd = take & ~we_i;
  wire logic wr = take & we_i & (sel_i == 4'hf);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_qos_rst; $past(rst_i) |-> unit_quality_field_o == '0; endproperty
  a_qos_rst: assert property (p_qos_rst)
    else $error("qos not zero");
  property p_qos0; wr && adr_i == OFS_QOS0 |=>
    unit_quality_field_o[31:0] == $past(dat_i); endproperty
  a_qos0: assert property (p_qos0) else $error("group 0 wrong");
  property p_qos3; wr && adr_i == OFS_QOS3 |=>
    unit_quality_field_o[127:96] == $past(dat_i); endproperty
  a_qos3: assert property (p_qos3) else $error("group 3 wrong");
  property p_keep; take && we_i && adr_i >= OFS_PARITY |=>
    $stable(unit_quality_field_o); endproperty
  a_keep: assert property (p_keep) else $error("qos disturbed");
  property p_cid0; rd && adr_i == OFS_CID0 |=>
    ack_o && dat_o == 32'h0000_000d; endproperty
  a_cid0: assert property (p_cid0) else $error("preamble wrong");
  property p_pid5; rd && adr_i == OFS_PID5 |=>
    ack_o && dat_o == '0; endproperty
  a_pid5: assert property (p_pid5) else $error("ident 5 not 0");
  property p_pid2; rd && adr_i == OFS_PID2 |=> dat_o[3]; endproperty
  a_pid2: assert property (p_pid2) else $error("ident 2 bit 3");
  property p_par; rd && adr_i == OFS_PARITY |=> dat_o[31:16] == '0; endproperty
  a_par: assert property (p_par) else $error("parity upper bits");
  property p_ack; ack_o |=> !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  c_par: cover property (rd && adr_i == OFS_PARITY);
  c_qos3: cover property (wr && adr_i == OFS_QOS3);
  c_irq: cover property (irq_o);
  c_err: cover property (err_o);
endmodule : iqr_regs_properties

bind iqr_regs iqr_regs_properties iqr_regs_properties_i (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .ctrl_parity_err_i(ctrl_parity_err_i), .irq_o(irq_o),
  .unit_parity_err_i(unit_parity_err_i), .unit_powered_i(unit_powered_i),
  .unit_quality_field_o(unit_quality_field_o));

// >>> bench/iqr_regs_test.sv
// self-checking bench for the quality, parity and identification bank
module iqr_regs_test import iqr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic ctrl_parity_err_i = 1'b0, unit_parity_err_i = 1'b0, ack_o, err_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, unit_powered_i = 32'h0, dat_o, rd, pat [4];
  logic [127:0] unit_quality_field_o;
  logic irq_o, e;
  int bad_count = 0, compares = 0;
  logic [7:0] idv [12] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h5a, 8'hc7,
    8'h2a, 8'h69, 8'h0d, 8'hf0, 8'h05, 8'hb1};
  always #12.5 clk_i = ~clk_i;
  iqr_regs iqr_regs_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .ctrl_parity_err_i, .unit_parity_err_i,
    .unit_powered_i, .unit_quality_field_o, .irq_o);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk_i);
    end while (!(ack_o | err_o));
    rd = dat_o;
    e = err_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic pulse(int n, logic c);
    @(posedge clk_i);
    {ctrl_parity_err_i, unit_parity_err_i} <= {c, ~c};
    repeat (n) @(posedge clk_i);
    {ctrl_parity_err_i, unit_parity_err_i} <= 2'b00;
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, 4'hf);
      chk("reset value", rd, 32'h0);
    end
  endtask : t_reset
  task automatic t_ident();
    for (int i = 0; i < 12; i++) begin
      wb(1'b1, 8'hd0 + 8'(i * 4), 32'hffff_ffff, 4'hf);
      wb(1'b0, 8'hd0 + 8'(i * 4), 32'h0, 4'hf);
      case (i)
        4: chk("ident 0", rd, {24'h0, idv[i]});
        5: chk("ident 1", rd, {24'h0, idv[i]});
        6: chk("ident 2", rd, {24'h0, idv[i]});
        7: chk("ident 3", rd, {24'h0, idv[i]});
        default: chk("ident", rd, {24'h0, idv[i]});
      endcase
    end
  endtask : t_ident
  task automatic t_qos();
    for (int g = 0; g < 4; g++) begin
      pat[g] = 32'h9abc_def0 + 32'(g * 32'h1111_1111);
      wb(1'b1, 8'(g * 4), pat[g], 4'hf);
    end
    for (int n = 0; n < 32; n++)
      chk("unit quality", 32'(unit_quality_field_o[4*n+:4]),
        32'(pat[n/8][4*(n%8)+:4]));
    wb(1'b1, OFS_QOS2, 32'h0, 4'h1);
    wb(1'b0, OFS_QOS2, 32'h0, 4'hf);
    chk("lane write", rd, pat[2] & 32'hffff_ff00);
  endtask : t_qos
  task automatic t_par();
    pulse(3, 1'b1);
    pulse(1, 1'b0);
    wb(1'b0, OFS_PARITY, 32'h0, 4'hf);
    chk("counts", rd, 32'h0000_0301);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hf);
    chk("status", rd, 32'h3);
    wb(1'b1, OFS_IRQ_ENABLE, 32'h1, 4'hf);
    chk("irq on", 32'(irq_o), 32'h1);
    wb(1'b1, OFS_IRQ_CLEAR, 32'h1, 4'hf);
    chk("irq cleared", 32'(irq_o), 32'h0);
    wb(1'b1, OFS_IRQ_ENABLE, 32'h2, 4'hf);
    chk("irq unit", 32'(irq_o), 32'h1);
    wb(1'b0, OFS_IRQ_ENABLE, 32'h0, 4'hf);
    chk("enable", rd, 32'h2);
    wb(1'b1, OFS_IRQ_ENABLE, 32'h0, 4'hf);
    chk("irq masked", 32'(irq_o), 32'h0);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hf);
    chk("status kept", rd, 32'h2);
    wb(1'b1, OFS_IRQ_CLEAR, 32'h2, 4'hf);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hf);
    chk("status cleared", rd, 32'h0);
    wb(1'b0, OFS_IRQ_CLEAR, 32'h0, 4'hf);
    chk("clear reads", rd, 32'h0);
    pulse(260, 1'b1);
    pulse(256, 1'b0);
    wb(1'b1, OFS_PARITY, 32'h0, 4'hf);
    wb(1'b0, OFS_PARITY, 32'h0, 4'hf);
    chk("saturated", rd, 32'h0000_ffff);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    chk("unmapped", 32'(e), 32'h1);
  endtask : t_par
  task automatic t_pwr();
    @(posedge clk_i);
    unit_powered_i <= 32'ha5c3_0f01;
    repeat (3) @(posedge clk_i);
    wb(1'b1, OFS_POWER, 32'h0, 4'hf);
    wb(1'b0, OFS_POWER, 32'h0, 4'hf);
    chk("power", rd, 32'ha5c3_0f01);
  endtask : t_pwr
  task automatic t_rst2();
    wb(1'b1, OFS_IRQ_ENABLE, 32'h3, 4'hf);
    chk("irq before reset", 32'(irq_o), 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq after reset", 32'(irq_o), 32'h0);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, 4'hf);
      chk("late reset", rd, 32'h0);
    end
    wb(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hf);
    chk("late status", rd, 32'h0);
    wb(1'b0, OFS_IRQ_ENABLE, 32'h0, 4'hf);
    chk("late enable", rd, 32'h0);
    wb(1'b0, OFS_POWER, 32'h0, 4'hf);
    chk("late power", rd, 32'ha5c3_0f01);
  endtask : t_rst2
  task automatic conclude();
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ident();
    t_qos();
    t_par();
    t_pwr();
    t_rst2();
    conclude();
  end
  initial begin
    #500000;
    bad_count++;
    conclude();
  end
endmodule : iqr_regs_test
